// File: pkg/dioac_pkg.sv
// shared constants and types for the drive io assembly codec
`default_nettype none
package dioac_pkg;
    // output format selector values
    localparam logic [7:0] FMT_DEFAULT = 8'h00; // factory default, same as extended
    localparam logic [7:0] FMT_BASIC = 8'h14; // instance 20
    localparam logic [7:0] FMT_EXT = 8'h15; // instance 21
    localparam logic [7:0] FMT_TERM = 8'h64; // instance 100
    localparam logic [7:0] FMT_USER = 8'h66; // instance 102
    // request byte 0 bit positions
    localparam int BIT_FWD = 0;
    localparam int BIT_REV = 1;
    localparam int BIT_ARST = 2;
    localparam int BIT_RUN_SRC = 5;
    localparam int BIT_SPD_SRC = 6;
    localparam int BIT_TERM_LO = 2; // five terminal bits 2..6 of byte 0
    // request byte 1 bit positions, instance 100
    localparam int BIT_TERM_F = 5;
    localparam int BIT_TERM_R = 6;
    localparam int BIT_TERM_RST = 7;
    // request masks that keep only defined bits
    localparam logic [7:0] MASK_B0_BASIC = 8'h05;
    localparam logic [7:0] MASK_B0_EXT = 8'h67;
    localparam logic [7:0] MASK_B0_TERM = 8'h7F;
    localparam logic [7:0] MASK_B1_TERM = 8'hE0;
    // status byte 0 bit positions
    localparam int ST_FAULTED = 0;
    localparam int ST_FWD = 2;
    localparam int ST_REV = 3;
    localparam int ST_READY = 4;
    localparam int ST_RUN_NET = 5;
    localparam int ST_SPD_NET = 6;
    localparam int ST_AT_REF = 7;
    // user mapping layout
    localparam int MAP_COUNT = 4;
    localparam int FC_WIDTH = 16;
    localparam logic [15:0] FC_UNASSIGNED = 16'h0000;
    // drive state codes in status byte 1
    typedef enum logic [7:0] {
        DS_STARTUP = 8'h01,
        DS_NOT_READY = 8'h02,
        DS_READY = 8'h03,
        DS_ENABLED = 8'h04,
        DS_STOPPING = 8'h05,
        DS_FAULT_STOP = 8'h06,
        DS_FAULTED = 8'h07
    } dioac_drive_state_type;
    // master end link states
    typedef enum logic {
        LS_IDLE = 1'b0,
        LS_WAIT = 1'b1
    } dioac_link_state_type;
    // master end register byte addresses
    localparam logic [7:0] REG_REQ_LO = 8'h00; // request bytes 0..3
    localparam logic [7:0] REG_REQ_HI = 8'h04; // request bytes 4..7
    localparam logic [7:0] REG_FORMAT = 8'h08; // output format in use
    localparam logic [7:0] REG_SEND = 8'h0C; // bit 0 sends one frame
    localparam logic [7:0] REG_RESP = 8'h10; // last status response
    localparam logic [7:0] REG_FLAGS = 8'h14; // bit 0 busy, bit 1 new response
    localparam logic [31:0] REQ_RESET = 32'h0000_0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: pkg/dioac_link_if.sv
// link carrying output assemblies and status responses between the ends
`default_nettype none
interface dioac_link_if;
    logic req_valid; // one-cycle pulse, frame present
    logic [63:0] req_data; // request bytes, byte n at bits 8n+7:8n
    logic rsp_valid; // one-cycle pulse, status present
    logic [31:0] rsp_data; // status bytes 0..3
    // documented device end
    modport device (input req_valid, input req_data, output rsp_valid, output rsp_data);
    // fieldbus master end
    modport master (output req_valid, output req_data, input rsp_valid, input rsp_data);
endinterface
`default_nettype wire

// File: design/dioac_device.sv
// device end: unpacks output assemblies and packs the status response
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`default_nettype none
// Function
// - direction flags follow motor rotation
// - ready flag set when drive ready and no fault or fault stop
// - run-source flag shows network run in effect
// - speed-source flag shows network speed in effect
// - at-speed only when actual equals reference
// - drive state byte codes one to seven
// - speeds sixteen bits, low byte first
// - instance 20 layout: forward, reset, speed
// - instance 21 adds reverse, source selects
// - run-source select picks network or local
// - speed-source select picks network or local
// - format values 21 and 0 equal
// - instance 100 run and terminal bits
// - instance 100 frequency per-unit word
// - instance 102 four words to mapped codes
// - user mappings apply only after reset or restart
// - duplicate mapping: lowest slot only effective
// - stopped ready networked: 70 and 03
// - decelerating state 05, accelerating 04
// - reverse at speed gives F8
// - formats latched only at the first edge after reset and at restart
module dioac_device (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    dioac_link_if.device LINK,
    input wire logic RESTART_I,
    input wire logic [7:0] FORMAT_SEL_I,
    input wire logic [63:0] USER_MAP_I,
    input wire logic LOCAL_RUN_FWD_I,
    input wire logic LOCAL_RUN_REV_I,
    input wire logic [15:0] LOCAL_SPEED_I,
    input wire logic MOTOR_FWD_I,
    input wire logic MOTOR_REV_I,
    input wire logic DRIVE_READY_I,
    input wire logic DRIVE_FAULT_I,
    input wire logic FAULT_STOP_I,
    input wire logic [15:0] SPEED_ACTUAL_I,
    output logic RUN_FWD_O,
    output logic RUN_REV_O,
    output logic ALARM_RESET_O,
    output logic [15:0] SPEED_REF_O,
    output logic [15:0] FREQ_CMD_O,
    output logic [6:0] TERMINAL_CMD_O,
    output logic RUN_SOURCE_NET_O,
    output logic SPEED_SOURCE_NET_O,
    output logic [3:0] FC_WRITE_O,
    output logic [63:0] FC_CODE_O,
    output logic [63:0] FC_DATA_O,
    output logic [7:0] ACTIVE_FORMAT_O
);
    // latched configuration
    logic cfg_loaded_q; // set at the first edge after reset
    logic [7:0] fmt_q; // output format in use
    logic [63:0] map_q; // user mapping function codes
    logic [3:0] map_ok_q; // mapping slot effective
    logic [3:0] map_ok_d;
    // network command state
    logic net_fwd_q;
    logic net_rev_q;
    logic net_arst_q;
    logic [15:0] net_speed_q;
    logic run_src_q;
    logic spd_src_q;
    logic [6:0] term_q;
    logic [63:0] fc_data_q;
    logic [3:0] fc_wr_q;
    // response registers
    logic rsp_valid_q;
    logic [31:0] rsp_data_q;
    logic take_q; // frame applied last edge, answer due now
    dioac_pkg::dioac_drive_state_type state_d;

    // restart loads the selector; any unknown value acts as extended
    wire logic fmt_known = (FORMAT_SEL_I == dioac_pkg::FMT_BASIC)
        || (FORMAT_SEL_I == dioac_pkg::FMT_TERM)
        || (FORMAT_SEL_I == dioac_pkg::FMT_USER);
    wire logic [7:0] fmt_norm = fmt_known ? FORMAT_SEL_I : dioac_pkg::FMT_EXT;
    wire logic cfg_load = !cfg_loaded_q || RESTART_I;

    // mapping slot valid only if nonzero and not used by a lower slot
    always_comb begin
        map_ok_d = 4'h0;
        for (int i = 0; i < dioac_pkg::MAP_COUNT; i++) begin
            map_ok_d[i] = (USER_MAP_I[16*i +: 16] != dioac_pkg::FC_UNASSIGNED);
            for (int j = 0; j < i; j++) begin
                if (USER_MAP_I[16*j +: 16] == USER_MAP_I[16*i +: 16]) begin
                    map_ok_d[i] = 1'b0;
                end
            end
        end
    end

    // configuration capture, only at the first edge after reset and at restart
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            cfg_loaded_q <= 1'b0;
            fmt_q <= dioac_pkg::FMT_EXT;
            map_q <= 64'h0;
            map_ok_q <= 4'h0;
        end else if (cfg_load) begin
            cfg_loaded_q <= 1'b1;
            fmt_q <= fmt_norm;
            map_q <= USER_MAP_I;
            map_ok_q <= map_ok_d;
        end
    end

    // format decode
    wire logic is_basic = (fmt_q == dioac_pkg::FMT_BASIC);
    wire logic is_ext = (fmt_q == dioac_pkg::FMT_EXT);
    wire logic is_term = (fmt_q == dioac_pkg::FMT_TERM);
    wire logic is_user = (fmt_q == dioac_pkg::FMT_USER);
    // received frame fields
    wire logic [7:0] rx_b0 = LINK.req_data[7:0];
    wire logic [7:0] rx_b1 = LINK.req_data[15:8];
    wire logic [15:0] rx_word = LINK.req_data[31:16]; // low byte in byte 2
    wire logic take = LINK.req_valid && cfg_loaded_q && !RESTART_I;
    wire logic take_cmd = take && !is_user;

    // next network command values; undefined bits never looked at
    wire logic net_fwd_d = take_cmd ? rx_b0[dioac_pkg::BIT_FWD] : net_fwd_q;
    wire logic net_rev_d = take_cmd
        ? (rx_b0[dioac_pkg::BIT_REV] && !is_basic) : net_rev_q;
    wire logic arst_rx = is_term
        ? rx_b1[dioac_pkg::BIT_TERM_RST] : rx_b0[dioac_pkg::BIT_ARST];
    wire logic net_arst_d = take_cmd ? arst_rx : net_arst_q;
    wire logic [15:0] net_speed_d = take_cmd ? rx_word : net_speed_q;
    wire logic run_src_d = (take && is_ext)
        ? rx_b0[dioac_pkg::BIT_RUN_SRC] : run_src_q;
    wire logic spd_src_d = (take && is_ext)
        ? rx_b0[dioac_pkg::BIT_SPD_SRC] : spd_src_q;
    wire logic [6:0] term_rx = {rx_b1[dioac_pkg::BIT_TERM_R], rx_b1[dioac_pkg::BIT_TERM_F],
        rx_b0[dioac_pkg::BIT_TERM_LO +: 5]};
    wire logic [6:0] term_d = (take && is_term) ? term_rx : term_q;
    // instance 102 words go to the effective mapped codes
    wire logic [3:0] fc_wr_d = (take && is_user) ? map_ok_q : 4'h0;
    wire logic [63:0] fc_data_d = (take && is_user) ? LINK.req_data : fc_data_q;

    // network command capture, cleared when configuration reloads
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            {net_fwd_q, net_rev_q, net_arst_q, run_src_q, spd_src_q} <= 5'h00;
            net_speed_q <= 16'h0000;
            term_q <= 7'h00;
        end else if (cfg_load) begin
            {net_fwd_q, net_rev_q, net_arst_q, run_src_q, spd_src_q} <= 5'h00;
            net_speed_q <= 16'h0000;
            term_q <= 7'h00;
        end else begin
            {net_fwd_q, net_rev_q, net_arst_q} <= {net_fwd_d, net_rev_d, net_arst_d};
            {run_src_q, spd_src_q} <= {run_src_d, spd_src_d};
            net_speed_q <= net_speed_d;
            term_q <= term_d;
        end
    end

    // source selection; basic and terminal formats always use the network
    wire logic run_net = is_ext ? run_src_q : (is_basic || is_term);
    wire logic spd_net = is_ext ? spd_src_q : (is_basic || is_term);
    wire logic run_fwd_d = run_net ? net_fwd_q : LOCAL_RUN_FWD_I;
    wire logic run_rev_d = run_net ? net_rev_q : LOCAL_RUN_REV_I;
    wire logic [15:0] speed_ref_d = (spd_net && !is_term)
        ? net_speed_q : LOCAL_SPEED_I;
    wire logic [15:0] freq_cmd_d = is_term ? net_speed_q : 16'h0000;

    // status terms
    wire logic moving = MOTOR_FWD_I || MOTOR_REV_I;
    wire logic run_req = run_fwd_d || run_rev_d;
    wire logic at_ref = moving && (SPEED_ACTUAL_I == speed_ref_d);
    wire logic ready = cfg_loaded_q && DRIVE_READY_I
        && !DRIVE_FAULT_I && !FAULT_STOP_I;

    // drive state code by priority
    always_comb begin
        if (!cfg_loaded_q) begin
            state_d = dioac_pkg::DS_STARTUP;
        end else if (DRIVE_FAULT_I) begin
            state_d = dioac_pkg::DS_FAULTED;
        end else if (FAULT_STOP_I) begin
            state_d = dioac_pkg::DS_FAULT_STOP;
        end else if (!DRIVE_READY_I) begin
            state_d = dioac_pkg::DS_NOT_READY;
        end else if (run_req) begin
            state_d = dioac_pkg::DS_ENABLED;
        end else if (moving) begin
            state_d = dioac_pkg::DS_STOPPING;
        end else begin
            state_d = dioac_pkg::DS_READY;
        end
    end

    // status byte 0; bit 1 reserved and zero
    wire logic [7:0] st_b0 = {at_ref, spd_net, run_net, ready, MOTOR_REV_I, MOTOR_FWD_I,
        1'b0, DRIVE_FAULT_I};
    wire logic [31:0] st_word = {SPEED_ACTUAL_I, state_d, st_b0};

    // response and user-side outputs; the answer waits one edge so the
    // status already shows the commands of the frame it answers
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            take_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 32'h0000_0000;
            fc_wr_q <= 4'h0;
            fc_data_q <= 64'h0;
            {RUN_FWD_O, RUN_REV_O, ALARM_RESET_O} <= 3'h0;
            {RUN_SOURCE_NET_O, SPEED_SOURCE_NET_O} <= 2'h0;
            SPEED_REF_O <= 16'h0000;
            FREQ_CMD_O <= 16'h0000;
            TERMINAL_CMD_O <= 7'h00;
        end else begin
            take_q <= take;
            rsp_valid_q <= take_q;
            rsp_data_q <= take_q ? st_word : rsp_data_q;
            fc_wr_q <= fc_wr_d;
            fc_data_q <= fc_data_d;
            {RUN_FWD_O, RUN_REV_O, ALARM_RESET_O} <= {run_fwd_d, run_rev_d, net_arst_q};
            {RUN_SOURCE_NET_O, SPEED_SOURCE_NET_O} <= {run_net, spd_net};
            SPEED_REF_O <= speed_ref_d;
            FREQ_CMD_O <= freq_cmd_d;
            TERMINAL_CMD_O <= term_q;
        end
    end

    // registered link and mapping outputs
    assign LINK.rsp_valid = rsp_valid_q;
    assign LINK.rsp_data = rsp_data_q;
    assign FC_WRITE_O = fc_wr_q;
    assign FC_DATA_O = fc_data_q;
    assign FC_CODE_O = map_q;
    assign ACTIVE_FORMAT_O = fmt_q;
endmodule
`default_nettype wire

// File: design/dioac_master.sv
// fieldbus master end: axi4-lite registers drive request frames
`default_nettype none
module dioac_master (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    dioac_link_if.master LINK,
    input wire logic [7:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    input wire logic [7:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I
);
    logic aw_got_q; // write address held
    logic w_got_q; // write data held
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] req_lo_q; // request bytes 0..3
    logic [31:0] req_hi_q; // request bytes 4..7
    logic [7:0] fmt_q; // output format the device uses
    logic [31:0] resp_q; // last status response
    logic resp_new_q; // response not yet seen by software
    logic req_valid_q;
    logic [63:0] req_data_q;
    dioac_pkg::dioac_link_state_type ls_q;

    // write strobe merge
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
            input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    // write decode, done once both halves are held
    wire logic wr_do = aw_got_q && w_got_q && !S_AXI_BVALID_O;
    wire logic wr_lo = wr_do && (waddr_q == dioac_pkg::REG_REQ_LO);
    wire logic wr_hi = wr_do && (waddr_q == dioac_pkg::REG_REQ_HI);
    wire logic wr_fmt = wr_do && (waddr_q == dioac_pkg::REG_FORMAT);
    wire logic wr_send = wr_do && (waddr_q == dioac_pkg::REG_SEND);
    wire logic wr_hit = wr_lo || wr_hi || wr_fmt || wr_send
        || (waddr_q == dioac_pkg::REG_RESP) || (waddr_q == dioac_pkg::REG_FLAGS);
    wire logic send = wr_send && wstrb_q[0] && wdata_q[0] && (ls_q == dioac_pkg::LS_IDLE);

    // read decode
    wire logic rd_do = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    wire logic [7:0] ra = S_AXI_ARADDR_I;
    wire logic rd_flags = rd_do && (ra == dioac_pkg::REG_FLAGS);
    wire logic rd_hit = (ra == dioac_pkg::REG_REQ_LO) || (ra == dioac_pkg::REG_REQ_HI)
        || (ra == dioac_pkg::REG_FORMAT) || (ra == dioac_pkg::REG_SEND)
        || (ra == dioac_pkg::REG_RESP) || (ra == dioac_pkg::REG_FLAGS);
    wire logic [31:0] flags = {30'h0, resp_new_q, (ls_q == dioac_pkg::LS_WAIT)};
    wire logic [31:0] rd_val = (ra == dioac_pkg::REG_REQ_LO) ? req_lo_q
        : (ra == dioac_pkg::REG_REQ_HI) ? req_hi_q
        : (ra == dioac_pkg::REG_FORMAT) ? {24'h0, fmt_q}
        : (ra == dioac_pkg::REG_RESP) ? resp_q
        : (ra == dioac_pkg::REG_FLAGS) ? flags : 32'h0000_0000;

    // frame shaping: undefined bits and fixed byte 1 sent as zero
    wire logic [7:0] b0 = req_lo_q[7:0];
    wire logic [7:0] b1 = req_lo_q[15:8];
    wire logic [63:0] frame = (fmt_q == dioac_pkg::FMT_BASIC)
        ? {32'h0, req_lo_q[31:16], 8'h00, b0 & dioac_pkg::MASK_B0_BASIC}
        : (fmt_q == dioac_pkg::FMT_TERM)
        ? {32'h0, req_lo_q[31:16], b1 & dioac_pkg::MASK_B1_TERM,
           b0 & dioac_pkg::MASK_B0_TERM}
        : (fmt_q == dioac_pkg::FMT_USER) ? {req_hi_q, req_lo_q}
        : {32'h0, req_lo_q[31:16], 8'h00, b0 & dioac_pkg::MASK_B0_EXT};

    // axi write channel handshakes
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            {S_AXI_AWREADY_O, S_AXI_WREADY_O, aw_got_q, w_got_q} <= 4'h0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O <= dioac_pkg::RESP_OKAY;
        end else begin
            S_AXI_AWREADY_O <= S_AXI_AWVALID_I && !S_AXI_AWREADY_O && !aw_got_q;
            S_AXI_WREADY_O <= S_AXI_WVALID_I && !S_AXI_WREADY_O && !w_got_q;
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
                aw_got_q <= 1'b1;
                waddr_q <= S_AXI_AWADDR_I;
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                aw_got_q <= 1'b0;
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
                w_got_q <= 1'b1;
                wdata_q <= S_AXI_WDATA_I;
                wstrb_q <= S_AXI_WSTRB_I;
            end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
                w_got_q <= 1'b0;
            end
            if (wr_do) begin
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O <= wr_hit ? dioac_pkg::RESP_OKAY : dioac_pkg::RESP_SLVERR;
            end else if (S_AXI_BREADY_I) begin
                S_AXI_BVALID_O <= 1'b0;
            end
        end
    end

    // axi read channel
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            S_AXI_ARREADY_O <= 1'b0;
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O <= 32'h0000_0000;
            S_AXI_RRESP_O <= dioac_pkg::RESP_OKAY;
        end else begin
            S_AXI_ARREADY_O <= S_AXI_ARVALID_I && !S_AXI_ARREADY_O && !S_AXI_RVALID_O;
            if (rd_do) begin
                S_AXI_RVALID_O <= 1'b1;
                S_AXI_RDATA_O <= rd_val;
                S_AXI_RRESP_O <= rd_hit ? dioac_pkg::RESP_OKAY : dioac_pkg::RESP_SLVERR;
            end else if (S_AXI_RREADY_I) begin
                S_AXI_RVALID_O <= 1'b0;
            end
        end
    end

    // registers, frame launch and response capture
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            req_lo_q <= dioac_pkg::REQ_RESET;
            req_hi_q <= dioac_pkg::REQ_RESET;
            fmt_q <= dioac_pkg::FMT_DEFAULT;
            resp_q <= 32'h0000_0000;
            resp_new_q <= 1'b0;
            req_valid_q <= 1'b0;
            req_data_q <= 64'h0;
            ls_q <= dioac_pkg::LS_IDLE;
        end else begin
            req_lo_q <= wr_lo ? merge(req_lo_q, wdata_q, wstrb_q) : req_lo_q;
            req_hi_q <= wr_hi ? merge(req_hi_q, wdata_q, wstrb_q) : req_hi_q;
            fmt_q <= (wr_fmt && wstrb_q[0]) ? wdata_q[7:0] : fmt_q;
            req_valid_q <= send;
            req_data_q <= send ? frame : req_data_q;
            case (ls_q)
                dioac_pkg::LS_IDLE: begin
                    ls_q <= send ? dioac_pkg::LS_WAIT : dioac_pkg::LS_IDLE;
                end
                default: begin
                    ls_q <= LINK.rsp_valid ? dioac_pkg::LS_IDLE : dioac_pkg::LS_WAIT;
                end
            endcase
            // new response wins over a read-clear in the same cycle
            if (LINK.rsp_valid) begin
                resp_q <= LINK.rsp_data;
                resp_new_q <= 1'b1;
            end else if (rd_flags) begin
                resp_new_q <= 1'b0;
            end
        end
    end

    assign LINK.req_valid = req_valid_q;
    assign LINK.req_data = req_data_q;
endmodule
`default_nettype wire

// File: tb/dioac_link_asserts.sv
// link protocol checker for the io assembly codec
`default_nettype none
module dioac_link_asserts (
    input wire logic CORE_CLK_I,
    input wire logic RESET_I,
    input wire logic req_valid,
    input wire logic [63:0] req_data,
    input wire logic rsp_valid,
    input wire logic [31:0] rsp_data
);
    // every check runs on the core clock and sleeps in reset
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);
    // drive state byte of the status
    wire logic [7:0] st_code = rsp_data[15:8];
    a_rsp_after_req: assert property (req_valid |-> ##2 rsp_valid)
        else $error("frame not answered");
    a_rsp_has_cause: assert property (rsp_valid |-> $past(req_valid, 2))
        else $error("status without frame");
    a_rsp_data_hold: assert property (!rsp_valid |-> $stable(rsp_data))
        else $error("status moved between answers");
    a_reserved_zero: assert property (rsp_valid |-> !rsp_data[1])
        else $error("reserved status bit set");
    a_state_range: assert property (rsp_valid |-> st_code inside {[8'h01:8'h07]})
        else $error("drive state out of range");
    a_ready_state: assert property (rsp_valid && st_code == 8'h03 |-> rsp_data[4])
        else $error("ready state without ready flag");
    a_at_ref_moving: assert property (rsp_valid && rsp_data[7] |-> |rsp_data[3:2])
        else $error("at speed while still");
    a_stop_moving: assert property (rsp_valid && st_code == 8'h05 |-> |rsp_data[3:2])
        else $error("stopping without direction");
    // main scenarios reached
    c_stop_ready: cover property (rsp_valid && rsp_data[15:0] == 16'h0370);
    c_rev_at_ref: cover property (rsp_valid && rsp_data[7:0] == 8'hF8);
    c_stopping: cover property (rsp_valid && rsp_data[15:8] == 8'h05);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// bench driving the master registers and the drive side of the device
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, rst = 1'h1, rs_go = 1'h0, mf = 1'h0, mr = 1'h0, rdy = 1'h1, flt = 1'h0;
    logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0;
    logic aw_r, w_r, b_v, ar_r, r_v, rfw, rrv, alm, rn, sn;
    logic [7:0] fs = 8'h00, aw_a = 8'h00, ar_a = 8'h00, fmt;
    logic [15:0] act = 16'h0000, spd, frq;
    logic [63:0] map = 64'h0000_0102_0305_0102, fcc, fcd;
    logic [31:0] w_d = 32'h0, r_d, rdv;
    logic [1:0] b_s, r_s, rs;
    logic [6:0] trm;
    logic [3:0] fcw, seen = 4'h0;
    int failures = 0, checked = 0;
    dioac_link_if link ();
    dioac_device dioac_device_inst (.CORE_CLK_I(clk), .RESET_I(rst), .LINK(link),
        .RESTART_I(rs_go), .FORMAT_SEL_I(fs), .USER_MAP_I(map), .LOCAL_RUN_FWD_I(1'h0),
        .LOCAL_RUN_REV_I(1'h0), .LOCAL_SPEED_I(16'h012C), .MOTOR_FWD_I(mf), .MOTOR_REV_I(mr),
        .DRIVE_READY_I(rdy), .DRIVE_FAULT_I(flt), .FAULT_STOP_I(1'h0), .SPEED_ACTUAL_I(act),
        .RUN_FWD_O(rfw), .RUN_REV_O(rrv), .ALARM_RESET_O(alm), .SPEED_REF_O(spd),
        .FREQ_CMD_O(frq), .TERMINAL_CMD_O(trm), .RUN_SOURCE_NET_O(rn), .SPEED_SOURCE_NET_O(sn),
        .FC_WRITE_O(fcw), .FC_CODE_O(fcc), .FC_DATA_O(fcd), .ACTIVE_FORMAT_O(fmt));
    dioac_master dioac_master_inst (.CORE_CLK_I(clk), .RESET_I(rst), .LINK(link),
        .S_AXI_AWADDR_I(aw_a), .S_AXI_AWVALID_I(aw_v), .S_AXI_AWREADY_O(aw_r),
        .S_AXI_WDATA_I(w_d), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(w_v), .S_AXI_WREADY_O(w_r),
        .S_AXI_BRESP_O(b_s), .S_AXI_BVALID_O(b_v), .S_AXI_BREADY_I(b_r),
        .S_AXI_ARADDR_I(ar_a), .S_AXI_ARVALID_I(ar_v), .S_AXI_ARREADY_O(ar_r),
        .S_AXI_RDATA_O(r_d), .S_AXI_RRESP_O(r_s), .S_AXI_RVALID_O(r_v), .S_AXI_RREADY_I(r_r));
    dioac_link_asserts dioac_link_asserts_inst (.CORE_CLK_I(clk), .RESET_I(rst),
        .req_valid(link.req_valid), .req_data(link.req_data), .rsp_valid(link.rsp_valid),
        .rsp_data(link.rsp_data));
    always #4 clk = ~clk;
    // sticky record of strobed function-code slots, idle in reset so no unknown sticks
    always @(posedge clk) if (!rst) seen <= seen | fcw;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // axi write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic a_ok = 1'h0;
        logic d_ok = 1'h0;
        @(posedge clk);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1'h1;
        w_v <= 1'h1;
        b_r <= 1'h1;
        while (!(a_ok && d_ok)) begin
            @(negedge clk);
            a_ok |= aw_r;
            d_ok |= w_r;
            @(posedge clk);
            aw_v <= !a_ok;
            w_v <= !d_ok;
        end
        do @(negedge clk); while (!b_v);
        rs = b_s;
        @(posedge clk);
        b_r <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        ar_a <= a;
        ar_v <= 1'h1;
        r_r <= 1'h1;
        do @(negedge clk); while (!ar_r);
        @(posedge clk);
        ar_v <= 1'h0;
        do @(negedge clk); while (!r_v);
        rdv = r_d;
        rs = r_s;
        @(posedge clk);
        r_r <= 1'h0;
    endtask
    // one frame out, wait for the new status, compare it
    task automatic fr(input logic [31:0] req, input logic [31:0] exp);
        wr(dioac_pkg::REG_REQ_LO, req);
        wr(dioac_pkg::REG_SEND, 32'h0000_0001);
        do rd(dioac_pkg::REG_FLAGS); while (!rdv[1]);
        rd(dioac_pkg::REG_RESP);
        chk(rdv, exp);
    endtask
    // new format at both ends, then a drive restart
    task automatic rst_to(input logic [7:0] f);
        wr(dioac_pkg::REG_FORMAT, {24'h0, f});
        fs <= f;
        rs_go <= 1'h1;
        @(posedge clk);
        rs_go <= 1'h0;
        repeat (2) @(posedge clk);
    endtask
    task automatic done(input string s);
        $display("test %0s finished", s);
    endtask
    task automatic summarize();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'h0;
        fr(32'h0708_0060, 32'h0000_0370);
        mf <= 1'h1;
        act <= 16'h0300;
        fr(32'h0708_0061, 32'h0300_0474);
        chk({rfw, spd}, {1'h1, 16'h0708});
        act <= 16'h0708;
        fr(32'h0708_0061, 32'h0708_04F4);
        act <= 16'h0600;
        fr(32'h0708_0060, 32'h0600_0574);
        done("forward");
        mf <= 1'h0;
        mr <= 1'h1;
        act <= 16'h012C;
        fr(32'h012C_0062, 32'h012C_04F8);
        chk({rrv, rn, sn}, 3'h7);
        fr(32'h012C_FF9A, 32'h012C_0598);
        chk({rrv, rn, sn}, 3'h0);
        mr <= 1'h0;
        act <= 16'h0000;
        flt <= 1'h1;
        fr(32'h0000_0060, 32'h0000_0761);
        flt <= 1'h0;
        rdy <= 1'h0;
        fr(32'h0000_0060, 32'h0000_0260);
        rdy <= 1'h1;
        wr(8'h40, 32'hFFFF_FFFF);
        chk(rs, dioac_pkg::RESP_SLVERR);
        rd(8'h40);
        chk({rs, rdv}, {dioac_pkg::RESP_SLVERR, 32'h0});
        done("reverse and faults");
        rst_to(dioac_pkg::FMT_BASIC);
        fr(32'h0708_0067, 32'h0000_0470);
        chk({rfw, rrv, alm, fmt}, {3'h5, 8'h14});
        fs <= dioac_pkg::FMT_DEFAULT;
        repeat (3) @(posedge clk);
        chk(fmt, 8'h14);
        rst_to(dioac_pkg::FMT_DEFAULT);
        chk(fmt, 8'h15);
        rst_to(dioac_pkg::FMT_TERM);
        fr(32'h4E20_E07D, 32'h0000_0470);
        chk({trm, frq, alm}, {7'h7F, 16'h4E20, 1'h1});
        rst_to(dioac_pkg::FMT_USER);
        wr(dioac_pkg::REG_REQ_HI, 32'h4444_3333);
        fr(32'h2222_1111, 32'h0000_0310);
        chk(fcd, 64'h4444_3333_2222_1111);
        chk(seen, 4'h3);
        map <= 64'h0;
        repeat (3) @(posedge clk);
        chk(fcc[31:0], 32'h0305_0102);
        done("formats");
        summarize();
    end
    // watchdog against a hung handshake
    initial begin
        #400000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
